// [cellphone_buzzer_gain_register.sv]
`timescale 1ns/1ns
// Operation
// - Bit 15 powers down cell amp, resets 1
// - Bits 14:8 cell gain code, reset 0x45
// - Codes 0x5d and above apply +12 dB
// - Under AGC gain field reads AGC gain
// - Bit 7 set when cell applied equals programmed, clamped to 0x5d
// - Under AGC bit 7 flags gain saturation
// - Bit 6 powers down buzzer amp, resets 1
// - Bits 5:2 buzzer code, reset 0xf
// - Bit 1 set when buzzer applied equals programmed
// - Cell soft-step one code per sample tick while AGC is off; under AGC the AGC code is applied at once
// - Buzzer soft-step one code per sample tick
module cellphone_buzzer_gain_register
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_en,
    input  wire logic        agc_enable,
    input  wire logic [6:0]  agc_gain,
    input  wire logic        cell_step_disable,
    input  wire logic        buzzer_step_disable,
    input  wire logic        fs_tick,
    output logic [15:0]      rd_data,
    output logic             rd_valid,
    output logic             cell_amp_powerdown,
    output logic [6:0]       cell_gain_applied,
    output logic             buzzer_amp_powerdown,
    output logic [3:0]       buzzer_gain_applied
);

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and decode

    logic                     cell_pd_ff;          // Cell amp power-down
    logic [6:0]               cell_gain_ff;        // Programmed cell code
    logic                     buz_pd_ff;           // Buzzer amp power-down
    logic [3:0]               buz_gain_ff;         // Programmed buzzer code
    logic [6:0]               cell_applied_ff;     // Cell code at the amp
    logic [3:0]               buz_applied_ff;      // Buzzer code at the amp
    logic                     cell_flag_ff;        // Settled or saturated
    logic                     buz_flag_ff;         // Buzzer settled
    logic [15:0]              rd_data_ff;          // Read data
    logic                     rd_valid_ff;         // Read strobe
    logic                     wr_hit;              // Write to this register
    logic                     rd_hit;              // Read of this register
    logic [6:0]               cell_target;         // Programmed code clamped
    logic [6:0]               nxt_cell_applied;    // Next cell applied code
    logic [3:0]               nxt_buz_applied;     // Next buzzer applied code
    logic                     nxt_cell_flag;       // Next cell flag
    gain_reg_pkg::gain_reg_t  readback;            // Read image
    gain_reg_pkg::gain_reg_t  wr_view;             // Write data by field

    assign wr_hit = wr_en && (reg_addr == gain_reg_pkg::REG_ADDR);
    assign rd_hit = rd_en && (reg_addr == gain_reg_pkg::REG_ADDR);
    assign wr_view = wr_data;

    // clamp to max
    // Codes above the top step all mean +12 dB, so stepping aims at the top step
    assign cell_target = (cell_gain_ff > gain_reg_pkg::CELL_MAX_CODE) ?
                         gain_reg_pkg::CELL_MAX_CODE : cell_gain_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Software-writable fields

    // Power-down bits, always writable
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            cell_pd_ff <= gain_reg_pkg::CELL_PD_RST;
            buz_pd_ff  <= gain_reg_pkg::BUZ_PD_RST;
        end
        else if (wr_hit)
        begin
            cell_pd_ff <= wr_data[gain_reg_pkg::CELL_PD_BIT];
            buz_pd_ff  <= wr_data[gain_reg_pkg::BUZ_PD_BIT];
        end
    end

    // Gain codes; flag bits and bit 0 of the write are dropped
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            cell_gain_ff <= gain_reg_pkg::CELL_GAIN_RST;
            buz_gain_ff  <= gain_reg_pkg::BUZ_GAIN_RST;
        end
        else if (wr_hit)
        begin
            if (!agc_enable)
                cell_gain_ff <= wr_data[gain_reg_pkg::CELL_GAIN_MSB:gain_reg_pkg::CELL_GAIN_LSB];
            buz_gain_ff <= wr_data[gain_reg_pkg::BUZ_GAIN_MSB:gain_reg_pkg::BUZ_GAIN_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Applied gain sequencing

    // Next cell applied code
    always_comb
    begin
        nxt_cell_applied = cell_applied_ff;
        if (agc_enable)
            nxt_cell_applied = agc_gain;           // AGC drives the amp directly
        else if (cell_step_disable)
            nxt_cell_applied = cell_target;        // Jump straight to target
        else if (fs_tick && (cell_applied_ff < cell_target))
            nxt_cell_applied = cell_applied_ff + 7'h01;
        else if (fs_tick && (cell_applied_ff > cell_target))
            nxt_cell_applied = cell_applied_ff - 7'h01;
    end

    // Next buzzer applied code
    always_comb
    begin
        nxt_buz_applied = buz_applied_ff;
        if (buzzer_step_disable)
            nxt_buz_applied = buz_gain_ff;
        else if (fs_tick && (buz_applied_ff < buz_gain_ff))
            nxt_buz_applied = buz_applied_ff + 4'h1;
        else if (fs_tick && (buz_applied_ff > buz_gain_ff))
            nxt_buz_applied = buz_applied_ff - 4'h1;
    end

    // Applied code registers
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            cell_applied_ff <= gain_reg_pkg::CELL_GAIN_RST;
            buz_applied_ff  <= gain_reg_pkg::BUZ_GAIN_RST;
        end
        else
        begin
            cell_applied_ff <= nxt_cell_applied;
            buz_applied_ff  <= nxt_buz_applied;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags

    // Flag meaning depends on AGC
    always_comb
    begin
        if (agc_enable)
            nxt_cell_flag = (cell_applied_ff == gain_reg_pkg::CELL_MIN_CODE) ||
                            (cell_applied_ff >= gain_reg_pkg::CELL_MAX_CODE);
        else
            nxt_cell_flag = (cell_applied_ff == cell_target);
    end

    // Flags lag the applied codes by one cycle; host reads are slow anyway
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            cell_flag_ff <= gain_reg_pkg::FLAG_RST;
            buz_flag_ff  <= gain_reg_pkg::FLAG_RST;
        end
        else
        begin
            cell_flag_ff <= nxt_cell_flag;
            buz_flag_ff  <= (buz_applied_ff == buz_gain_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path

    // Read image assembly
    always_comb
    begin
        readback.cell_amp_powerdown      = cell_pd_ff;
        readback.cell_amp_gain_code      = agc_enable ? agc_gain : cell_gain_ff;
        readback.cell_amp_settled_flag   = cell_flag_ff;
        readback.buzzer_amp_powerdown    = buz_pd_ff;
        readback.buzzer_amp_gain_code    = buz_gain_ff;
        readback.buzzer_amp_settled_flag = buz_flag_ff;
        readback.reserved                = 1'h0;
    end

    // Registered read data; unmapped reads return zero
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            rd_data_ff  <= 16'h0000;
            rd_valid_ff <= 1'h0;
        end
        else
        begin
            rd_valid_ff <= rd_en;
            if (rd_en)
                rd_data_ff <= rd_hit ? readback : 16'h0000;
        end
    end

    assign rd_data              = rd_data_ff;
    assign rd_valid             = rd_valid_ff;
    assign cell_amp_powerdown   = cell_pd_ff;
    assign cell_gain_applied    = cell_applied_ff;
    assign buzzer_amp_powerdown = buz_pd_ff;
    assign buzzer_gain_applied  = buz_applied_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_reset_pd;
        @(posedge clock)
        !nrst |=> cell_pd_ff && buz_pd_ff && (cell_gain_ff == gain_reg_pkg::CELL_GAIN_RST);
    endproperty
    a_reset_pd: assert property (p_reset_pd) else $error("reset values wrong");
    property p_buz_pd_write;
        @(posedge clock) disable iff (!nrst)
        wr_hit |=> buzzer_amp_powerdown == $past(wr_view.buzzer_amp_powerdown);
    endproperty
    a_buz_pd_write: assert property (p_buz_pd_write) else $error("buzzer pd write lost");
    property p_cell_write;
        @(posedge clock) disable iff (!nrst)
        wr_hit && !agc_enable |=> cell_gain_ff == $past(wr_view.cell_amp_gain_code);
    endproperty
    a_cell_write: assert property (p_cell_write) else $error("cell gain write lost");
    property p_cell_clamp;
        @(posedge clock) disable iff (!nrst)
        !agc_enable && cell_step_disable |=> cell_gain_applied <= gain_reg_pkg::CELL_MAX_CODE;
    endproperty
    a_cell_clamp: assert property (p_cell_clamp) else $error("cell gain above max");
    property p_agc_read;
        @(posedge clock) disable iff (!nrst)
        rd_hit && agc_enable |=> rd_data[14:8] == $past(agc_gain);
    endproperty
    a_agc_read: assert property (p_agc_read) else $error("agc gain not read");
    // Release edge skipped: the flag still holds its reset value there
    property p_cell_flag;
        @(posedge clock) disable iff (!nrst)
        nrst && !agc_enable |=> cell_flag_ff == $past(cell_applied_ff == cell_target);
    endproperty
    a_cell_flag: assert property (p_cell_flag) else $error("cell settled flag wrong");
    property p_sat_flag;
        @(posedge clock) disable iff (!nrst)
        agc_enable && (cell_applied_ff == gain_reg_pkg::CELL_MIN_CODE) |=> cell_flag_ff;
    endproperty
    a_sat_flag: assert property (p_sat_flag) else $error("saturation not flagged");
    property p_buz_write;
        @(posedge clock) disable iff (!nrst)
        wr_hit |=> buz_gain_ff == $past(wr_view.buzzer_amp_gain_code);
    endproperty
    a_buz_write: assert property (p_buz_write) else $error("buzzer code write lost");
    property p_buz_flag;
        @(posedge clock) disable iff (!nrst)
        (buz_applied_ff != buz_gain_ff) |=> !buz_flag_ff;
    endproperty
    a_buz_flag: assert property (p_buz_flag) else $error("buzzer flag set early");
    property p_rsvd;
        @(posedge clock) disable iff (!nrst) rd_valid |-> !rd_data[gain_reg_pkg::RSVD_BIT];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_cell_step;
        @(posedge clock) disable iff (!nrst)
        !agc_enable && !cell_step_disable && fs_tick && (cell_applied_ff < cell_target)
        |=> cell_applied_ff == $past(cell_applied_ff) + 7'h01;
    endproperty
    a_cell_step: assert property (p_cell_step) else $error("cell step wrong");
    property p_buz_hold;
        @(posedge clock) disable iff (!nrst)
        !buzzer_step_disable && !fs_tick |=> $stable(buz_applied_ff);
    endproperty
    a_buz_hold: assert property (p_buz_hold) else $error("buzzer moved without tick");
    property p_agc_lock;
        @(posedge clock) disable iff (!nrst)
        wr_hit && agc_enable |=> $stable(cell_gain_ff);
    endproperty
    a_agc_lock: assert property (p_agc_lock) else $error("agc field overwritten");
    c_cell_settle: cover property (@(posedge clock) disable iff (!nrst)
        !cell_flag_ff ##1 cell_flag_ff && !agc_enable);
    c_buz_settle: cover property (@(posedge clock) disable iff (!nrst)
        !buz_flag_ff ##1 buz_flag_ff);
    c_agc_sat: cover property (@(posedge clock) disable iff (!nrst) agc_enable && cell_flag_ff);
endmodule

// [gain_reg_pkg.sv]
package gain_reg_pkg;

    // Register location and field layout
    localparam logic [7:0] REG_ADDR       = 8'h1f;
    localparam int         CELL_PD_BIT    = 15;
    localparam int         CELL_GAIN_MSB  = 14;
    localparam int         CELL_GAIN_LSB  = 8;
    localparam int         CELL_FLAG_BIT  = 7;
    localparam int         BUZ_PD_BIT     = 6;
    localparam int         BUZ_GAIN_MSB   = 5;
    localparam int         BUZ_GAIN_LSB   = 2;
    localparam int         BUZ_FLAG_BIT   = 1;
    localparam int         RSVD_BIT       = 0;

    // Reset values
    localparam logic       CELL_PD_RST    = 1'h1;
    localparam logic [6:0] CELL_GAIN_RST  = 7'h45;
    localparam logic       BUZ_PD_RST     = 1'h1;
    localparam logic [3:0] BUZ_GAIN_RST   = 4'hf;
    localparam logic       FLAG_RST       = 1'h0;

    // Cell gain limits: code 0 is -34.5 dB, code 0x5d and above give +12 dB
    localparam logic [6:0] CELL_MIN_CODE  = 7'h00;
    localparam logic [6:0] CELL_MAX_CODE  = 7'h5d;

    // Register image as read back
    typedef struct packed {
        logic       cell_amp_powerdown;
        logic [6:0] cell_amp_gain_code;
        logic       cell_amp_settled_flag;
        logic       buzzer_amp_powerdown;
        logic [3:0] buzzer_amp_gain_code;
        logic       buzzer_amp_settled_flag;
        logic       reserved;
    } gain_reg_t;

endpackage

// [host_model.sv]
`timescale 1ns/1ns
// Host on the register port: one request at a time, driven just after the edge
module host_model
(
    input  wire logic        clock,
    output logic [7:0]       reg_addr,
    output logic             wr_en,
    output logic [15:0]      wr_data,
    output logic             rd_en,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid
);
    // Idle bus before the first request
    initial
    begin
        reg_addr = 8'h00;
        wr_en    = 1'b0;
        wr_data  = 16'h0000;
        rd_en    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One write; released lines flip so a stale value never looks current
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        wr_data  <= {d[15:1], 1'b0};
        wr_en    <= 1'b1;
        @(posedge clock);
        wr_en    <= 1'b0;
        reg_addr <= ~a;
        wr_data  <= ~d;
    endtask
    // One read; answer taken at the edge where rd_valid is seen
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(posedge clock);
        reg_addr <= a;
        rd_en    <= 1'b1;
        @(posedge clock);
        rd_en    <= 1'b0;
        @(posedge clock);
        d        = rd_data;
        v        = rd_valid;
        reg_addr <= ~a;
    endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
    logic        clock = 1'b0, nrst = 1'b0, wr_en, rd_en, rd_valid, vld;
    logic        agc_enable, cell_step_disable, buzzer_step_disable, fs_tick;
    logic        cell_amp_powerdown, buzzer_amp_powerdown, p_cpd, p_bpd;
    logic [7:0]  reg_addr;
    logic [15:0] wr_data, rd_data, rdat, wd;
    logic [6:0]  agc_gain, cell_gain_applied, p_cell, e_cell, g;
    logic [3:0]  buzzer_gain_applied, p_buz, e_buz;
    logic [6:0]  corner [4] = '{7'h5d, 7'h5e, 7'h7f, 7'h00};
    int          err_total = 0, cmp_count = 0, cycles = 0;
    integer      seed = 5;
    // Clock at 100 MHz
    always #5 clock = ~clock;
    cellphone_buzzer_gain_register u_cellphone_buzzer_gain_register (.clock(clock), .nrst(nrst),
        .reg_addr(reg_addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
        .agc_enable(agc_enable), .agc_gain(agc_gain), .cell_step_disable(cell_step_disable),
        .buzzer_step_disable(buzzer_step_disable), .fs_tick(fs_tick), .rd_data(rd_data),
        .rd_valid(rd_valid), .cell_amp_powerdown(cell_amp_powerdown),
        .cell_gain_applied(cell_gain_applied), .buzzer_amp_powerdown(buzzer_amp_powerdown),
        .buzzer_gain_applied(buzzer_gain_applied));
    host_model u_host_model (.clock(clock), .reg_addr(reg_addr), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid));
    ////////////////////////////////////////////////////////////////////////////////
    // Codes above the top step all apply the top gain
    function automatic logic [6:0] cell_target(input logic [6:0] c);
        return (c > gain_reg_pkg::CELL_MAX_CODE) ? gain_reg_pkg::CELL_MAX_CODE : c;
    endfunction
    // Expected read word from the bench's own view of the fields
    function automatic logic [15:0] exp_word(input logic [6:0] gf, input logic cf, bf);
        return {p_cpd, gf, cf, p_bpd, p_buz, bf, 1'b0};
    endfunction
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Read one word and compare it, valid strobe included
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] exp);
        u_host_model.reg_read(a, rdat, vld);
        check({n, "_valid"}, {15'h0000, vld}, 16'h0001);
        check(n, rdat, exp);
    endtask
    // Amplifier controls seen at the outputs
    task automatic out_chk(input string n);
        check(n, {cell_amp_powerdown, cell_gain_applied, buzzer_amp_powerdown,
            buzzer_gain_applied, 3'h0}, {p_cpd, e_cell, p_bpd, e_buz, 3'h0});
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard; the longest walk is at most 100 ticks of six cycles, 600 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {agc_enable, agc_gain, fs_tick} = 9'h000;
        {cell_step_disable, buzzer_step_disable} = 2'b11;
        {p_cpd, p_cell, p_bpd, p_buz} = {1'b1, 7'h45, 1'b1, 4'hf};
        {e_cell, e_buz} = {7'h45, 4'hf};
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        out_chk("reset_out");
        rd_chk("reset_word", 8'h1f, exp_word(p_cell, 1'b1, 1'b1));
        // Other address: write ignored, read answers zero
        u_host_model.reg_write(8'h1e, 16'h0000);
        rd_chk("unmapped", 8'h1e, 16'h0000);
        // The stray write must not have touched this register
        rd_chk("unmapped_keep", 8'h1f, exp_word(p_cell, 1'b1, 1'b1));
        // Jumps with corners first, random data in the flag bits
        for (int i = 0; i < 12; i++)
        begin
            wd = $random(seed);
            if (i < 4)
                wd[14:8] = corner[i];
            {p_cpd, p_cell, p_bpd, p_buz} = {wd[15:8], wd[6:2]};
            {e_cell, e_buz} = {cell_target(p_cell), p_buz};
            u_host_model.reg_write(gain_reg_pkg::REG_ADDR, wd);
            repeat (2) @(posedge clock);
            out_chk("jump_out");
            rd_chk("jump_word", 8'h1f, exp_word(p_cell, 1'b1, 1'b1));
        end
        // Soft-step: one code per tick, flags low until target reached
        {cell_step_disable, buzzer_step_disable} <= 2'b00;
        for (int j = 0; j < 2; j++)
        begin
            wd = $random(seed);
            {p_cpd, p_cell, p_bpd, p_buz} = {wd[15:8], wd[6:2]};
            u_host_model.reg_write(gain_reg_pkg::REG_ADDR, wd);
            for (int k = 0; k < 100 && {e_cell, e_buz} !== {cell_target(p_cell), p_buz}; k++)
            begin
                rd_chk("step_word", 8'h1f, exp_word(p_cell, e_cell == cell_target(p_cell),
                    e_buz == p_buz));
                @(posedge clock);
                fs_tick <= 1'b1;
                @(posedge clock);
                fs_tick <= 1'b0;
                g = cell_target(p_cell);
                e_cell = (e_cell < g) ? e_cell + 7'h01 : (e_cell > g) ? e_cell - 7'h01 : e_cell;
                e_buz = (e_buz < p_buz) ? e_buz + 4'h1 : (e_buz > p_buz) ? e_buz - 4'h1 : e_buz;
                @(posedge clock);
                out_chk("step_out");
            end
            rd_chk("step_done", 8'h1f, exp_word(p_cell, 1'b1, 1'b1));
        end
        // AGC owns the cell gain; host cell gain writes must be dropped
        agc_enable <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            g = (i < 4) ? corner[3 - i] : 7'($unsigned($random(seed)) % 93);
            g = (g > 7'h5d) ? 7'h5d - 7'h01 : g;
            @(posedge clock);
            agc_gain <= g;
            wd = $random(seed);
            wd[14:8] = ~p_cell;
            wd[5:2] = p_buz;
            {p_cpd, p_bpd} = {wd[15], wd[6]};
            u_host_model.reg_write(gain_reg_pkg::REG_ADDR, wd);
            e_cell = g;
            repeat (2) @(posedge clock);
            out_chk("agc_out");
            rd_chk("agc_word", 8'h1f, exp_word(g, g == 7'h00 || g >= 7'h5d, 1'b1));
        end
        agc_enable <= 1'b0;
        cell_step_disable <= 1'b1;
        repeat (3) @(posedge clock);
        e_cell = cell_target(p_cell);
        out_chk("agc_off_out");
        rd_chk("agc_off_word", 8'h1f, exp_word(p_cell, 1'b1, 1'b1));
        end_sim();
    end
endmodule
